//--- rtl/slsm_supervisor.sv
`timescale 1ns/1ps
// Overview of operation
// - Eight consecutive transmission errors start the communication error action.
// - Checksum failure on a frame for this station counts, code 71.
// - Parity, framing or overrun reception fault counts, code 72 or 73.
// - One error per frame; after fifteen, stop counting until next header.
// - Any frame passing checksum clears the transmission error counter; here a counted error in the same cycle wins.
// - Link silence beyond the detection time starts the error action.
// - Silence time is 0 for disabled, or 1 to 60 seconds; settings 61 to 63 are acted on unclamped.
// - Any frame passing checksum restarts the silence timing.
// - While faulted, keep applying the commands in force before the error; in trip the run direction is cleared.
// - Per-unit frequency is signed, -20000 to +20000, full scale maximum.
// - Hertz frequency ranges 0.00 to 400.00 in 0.01 Hz steps.
// - When the per-unit command is nonzero it wins over hertz.
// - Out-of-range writes are stored; the acted-on value is clamped.
// - Reading a command returns the last written value, not the final.
// - Analog output command is signed, -20000 to +20000 for full output.
// - Each on-to-off change of the reset bit gives an alarm reset.
// - Under link operation run direction comes from link, not terminals.
// - Listed functions come only from link under link operation.
// - Listed functions come only from terminals under link operation.
// - Each of nine inputs acts by its own function setting.
// - Digital outputs follow the link-written digital output command.
// - Action select: stop, run then stop, run unless late, run and resume.
// - Error action timer is 0.0 to 60.0 seconds.
// - No action before first header after power-up, nor without link control.
module slsm_supervisor
    import slsm_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES
)
(
    input  wire logic                      ref_clk,
    input  wire logic                      rst_n,
    input  wire slsm_link_evt_type         link_evt,
    input  wire slsm_cfg_type              cfg,
    input  wire logic                      link_freq_mode,
    input  wire logic                      link_run_mode,
    input  wire logic                      cmd_wr_en,
    input  wire logic                      cmd_rd_en,
    input  wire logic [7:0]                cmd_sel,
    input  wire logic [15:0]               cmd_wdata,
    input  wire logic [1:0]                term_run_dir,
    input  wire logic [NUM_X-1:0]          multi_function_inputs,
    input  wire logic [NUM_X-1:0][5:0]     input_function_settings,
    output logic [15:0]                    cmd_rdata_q,
    output logic signed [16:0]             freq_cmd_q,
    output logic                           freq_is_per_unit_q,
    output logic [1:0]                     run_direction_cmd_q,
    output logic [NUM_FUNC-1:0]            func_active_q,
    output logic [15:0]                    digital_out_q,
    output logic signed [16:0]             analog_out_q,
    output logic                           alarm_reset_q,
    output logic                           link_fault_trip_q,
    output logic                           link_hold_q,
    output logic [7:0]                     last_err_code_q,
    output logic [3:0]                     err_count_q
);

    // Link-written command registers.
    logic [15:0]    freq_cmd_per_unit_q;
    logic [15:0]    freq_cmd_hertz_q;
    logic [15:0]    run_operation_cmd_q;
    logic [15:0]    general_digital_out_cmd_q;
    logic [15:0]    general_analog_out_cmd_q;
    logic           rst_bit_prev_q;

    // Supervision state.
    slsm_state_type state_q;
    slsm_state_type state_d;
    logic           armed_q;
    logic           frame_err_seen_q;
    logic [3:0]     frame_err_total_q;
    logic [9:0]     silence_cnt_q;
    logic [9:0]     act_cnt_q;
    logic           tick;

    // Write and read decode.
    wire wr_pu  = cmd_wr_en && (cmd_sel == IDX_FREQ_PU);
    wire wr_hz  = cmd_wr_en && (cmd_sel == IDX_FREQ_HZ);
    wire wr_run = cmd_wr_en && (cmd_sel == IDX_RUN_OP);
    wire wr_do  = cmd_wr_en && (cmd_sel == IDX_DIG_OUT);
    wire wr_ao  = cmd_wr_en && (cmd_sel == IDX_ANA_OUT);

    logic [15:0] rd_mux;
    always_comb
    begin
        if (cmd_sel == IDX_FREQ_PU)
            rd_mux = freq_cmd_per_unit_q;
        else if (cmd_sel == IDX_FREQ_HZ)
            rd_mux = freq_cmd_hertz_q;
        else if (cmd_sel == IDX_RUN_OP)
            rd_mux = run_operation_cmd_q;
        else if (cmd_sel == IDX_DIG_OUT)
            rd_mux = general_digital_out_cmd_q;
        else if (cmd_sel == IDX_ANA_OUT)
            rd_mux = general_analog_out_cmd_q;
        else
            rd_mux = 16'h0000;
    end

    slsm_tick_div #(
        .DIV (TICK_DIV)
    ) u_tick (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .tick_q  (tick)
    );

    // Clamped copies of the stored commands; the hertz value is unsigned.
    logic signed [16:0] pu_clamped;
    logic signed [16:0] hz_clamped;
    logic signed [16:0] ao_clamped;

    slsm_clamp #(.W(17), .LO(PU_MIN), .HI(PU_MAX)) u_clamp_pu (
        .value_in  ({freq_cmd_per_unit_q[15], freq_cmd_per_unit_q}),
        .value_out (pu_clamped)
    );
    slsm_clamp #(.W(17), .LO(HZ_MIN), .HI(HZ_MAX)) u_clamp_hz (
        .value_in  ({1'b0, freq_cmd_hertz_q}),
        .value_out (hz_clamped)
    );
    slsm_clamp #(.W(17), .LO(PU_MIN), .HI(PU_MAX)) u_clamp_ao (
        .value_in  ({general_analog_out_cmd_q[15], general_analog_out_cmd_q}),
        .value_out (ao_clamped)
    );

    // Error event qualification: at most one per frame, and a burst limit per header.
    wire rx_fault   = link_evt.parity_err || link_evt.other_err;
    wire any_err    = link_evt.crc_bad_own || rx_fault;
    wire err_locked = frame_err_seen_q || (frame_err_total_q == ERR_FRAME_LIMIT);
    wire err_count  = any_err && !err_locked && !link_evt.soh;
    wire err_trip   = (err_count_q == ERR_TRIP_COUNT);

    // Silence and action timers, both in ticks of the divider.
    wire [9:0] silence_limit = 10'(cfg.silence_sec * TICKS_PER_SEC);
    wire       silence_on    = (cfg.silence_sec != 6'h00);
    wire       silence_trip  = silence_on && (silence_cnt_q >= silence_limit);
    wire [9:0] act_limit     = (cfg.action_timer > ACT_TIMER_MAX) ? ACT_TIMER_MAX
                                                                 : cfg.action_timer;
    wire       act_expired   = (act_cnt_q >= act_limit);
    wire       link_ctrl     = link_freq_mode || link_run_mode;
    wire       fault_event   = armed_q && link_ctrl && (err_trip || silence_trip);
    wire       recovered     = link_evt.crc_ok;
    wire       rst_fall      = rst_bit_prev_q && !run_operation_cmd_q[RUN_RST_BIT];

    // Error action sequencing.
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_NORMAL:
                if (fault_event)
                    state_d = (cfg.action_sel == ACT_STOP_NOW) ? ST_TRIP : ST_HOLD;
            ST_HOLD:
                case (cfg.action_sel)
                    ACT_STOP_NOW:    state_d = ST_TRIP;
                    ACT_RUN_TIMED:   if (act_expired) state_d = ST_TRIP;
                    ACT_RUN_OR_TRIP:
                        if (recovered)
                            state_d = ST_NORMAL;
                        else if (act_expired)
                            state_d = ST_TRIP;
                    default:         if (recovered) state_d = ST_NORMAL;
                endcase
            ST_TRIP:
                if (rst_fall)
                    state_d = ST_NORMAL;
            default:
                state_d = ST_NORMAL;
        endcase
    end

    // Per-function source selection; mixed functions take either source.
    logic [NUM_FUNC-1:0] func_term;
    logic [NUM_FUNC-1:0] func_link;
    always_comb
    begin
        func_term = '0;
        func_link = '0;
        for (int i = 0; i < NUM_X; i++)
        begin
            for (int f = 0; f < NUM_FUNC; f++)
            begin
                if (input_function_settings[i] == 6'(f))
                begin
                    func_term[f] = func_term[f] | multi_function_inputs[i];
                    func_link[f] = func_link[f] | run_operation_cmd_q[RUN_X_LSB + i];
                end
            end
        end
    end

    wire [NUM_FUNC-1:0] func_sel = link_run_mode
        ? ((func_link & ~FUNC_TERM_ONLY) | (func_term & ~FUNC_LINK_ONLY))
        : func_term;
    wire [1:0] run_sel = link_run_mode
        ? {run_operation_cmd_q[RUN_REV_BIT], run_operation_cmd_q[RUN_FWD_BIT]}
        : term_run_dir;
    wire use_pu = (freq_cmd_per_unit_q != 16'h0000);

    // Command registers keep what the link wrote, range checks come later.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            freq_cmd_per_unit_q       <= CMD_RESET_VAL;
            freq_cmd_hertz_q          <= CMD_RESET_VAL;
            run_operation_cmd_q       <= CMD_RESET_VAL;
            general_digital_out_cmd_q <= CMD_RESET_VAL;
            general_analog_out_cmd_q  <= CMD_RESET_VAL;
            rst_bit_prev_q            <= 1'b0;
            cmd_rdata_q               <= 16'h0000;
        end
        else
        begin
            if (wr_pu)  freq_cmd_per_unit_q       <= cmd_wdata;
            if (wr_hz)  freq_cmd_hertz_q          <= cmd_wdata;
            if (wr_run) run_operation_cmd_q       <= cmd_wdata;
            if (wr_do)  general_digital_out_cmd_q <= cmd_wdata;
            if (wr_ao)  general_analog_out_cmd_q  <= cmd_wdata;
            rst_bit_prev_q <= run_operation_cmd_q[RUN_RST_BIT];
            if (cmd_rd_en)
                cmd_rdata_q <= rd_mux;
        end
    end

    // Transmission error counter; a counted error beats a same-cycle clear.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            err_count_q       <= 4'h0;
            frame_err_seen_q  <= 1'b0;
            frame_err_total_q <= 4'h0;
            last_err_code_q   <= 8'h00;
            armed_q           <= 1'b0;
        end
        else
        begin
            if (link_evt.soh)
                armed_q <= 1'b1;
            if (err_count && !err_trip)
                err_count_q <= err_count_q + 4'h1;
            else if (link_evt.crc_ok && !err_count)
                err_count_q <= 4'h0;
            if (link_evt.soh)
            begin
                frame_err_seen_q  <= 1'b0;
                frame_err_total_q <= 4'h0;
            end
            else if (err_count)
            begin
                frame_err_seen_q  <= 1'b1;
                frame_err_total_q <= frame_err_total_q + 4'h1;
            end
            if (err_count)
                last_err_code_q <= link_evt.crc_bad_own ? ERR_CODE_CRC :
                                   link_evt.parity_err  ? ERR_CODE_PARITY :
                                                          ERR_CODE_OTHER;
        end
    end

    // Silence timer restarts on every good frame; the action timer runs only in hold.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            silence_cnt_q <= 10'h000;
            act_cnt_q     <= 10'h000;
            state_q       <= ST_NORMAL;
        end
        else
        begin
            if (link_evt.crc_ok)
                silence_cnt_q <= 10'h000;
            else if (tick && !silence_trip)
                silence_cnt_q <= silence_cnt_q + 10'h001;
            if (state_q != ST_HOLD)
                act_cnt_q <= 10'h000;
            else if (tick && !act_expired)
                act_cnt_q <= act_cnt_q + 10'h001;
            state_q <= state_d;
        end
    end

    // Applied outputs freeze outside normal state so the pre-error commands persist, except that trip clears the run direction.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            freq_cmd_q          <= 17'sd0;
            freq_is_per_unit_q  <= 1'b0;
            run_direction_cmd_q <= 2'b00;
            func_active_q       <= '0;
            digital_out_q       <= 16'h0000;
            analog_out_q        <= 17'sd0;
            alarm_reset_q       <= 1'b0;
            link_fault_trip_q   <= 1'b0;
            link_hold_q         <= 1'b0;
        end
        else
        begin
            alarm_reset_q     <= rst_fall;
            link_fault_trip_q <= (state_d == ST_TRIP);
            link_hold_q       <= (state_d == ST_HOLD);
            if (state_d == ST_TRIP)
                run_direction_cmd_q <= 2'b00;
            else if (state_d == ST_NORMAL)
                run_direction_cmd_q <= run_sel;
            if (state_d == ST_NORMAL)
            begin
                freq_cmd_q         <= use_pu ? pu_clamped : hz_clamped;
                freq_is_per_unit_q <= use_pu;
                func_active_q      <= func_sel;
                digital_out_q      <= general_digital_out_cmd_q;
                analog_out_q       <= ao_clamped;
            end
        end
    end

endmodule

//--- inc/slsm_pkg.sv
package slsm_pkg;

    // Clock and timing base.
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned TICK_MS         = 100;
    localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned TICKS_PER_SEC   = 1000 / TICK_MS;

    // Transmission error counting.
    localparam logic [3:0]  ERR_TRIP_COUNT  = 4'h8;
    localparam logic [3:0]  ERR_FRAME_LIMIT = 4'hF;
    localparam logic [7:0]  ERR_CODE_CRC    = 8'h47;
    localparam logic [7:0]  ERR_CODE_PARITY = 8'h48;
    localparam logic [7:0]  ERR_CODE_OTHER  = 8'h49;

    // Setting limits: silence in seconds, action timer in tenths of a second.
    localparam logic [5:0]  SILENCE_MAX_SEC = 6'h3C;
    localparam logic [9:0]  ACT_TIMER_MAX   = 10'h258;

    // Command value limits.
    localparam logic signed [16:0] PU_MIN   = -17'sd20000;
    localparam logic signed [16:0] PU_MAX   = 17'sd20000;
    localparam logic signed [16:0] HZ_MIN   = 17'sd0;
    localparam logic signed [16:0] HZ_MAX   = 17'sd40000;

    // Command register indices on the link write and read port.
    localparam logic [7:0]  IDX_FREQ_PU     = 8'h01;
    localparam logic [7:0]  IDX_FREQ_HZ     = 8'h05;
    localparam logic [7:0]  IDX_RUN_OP      = 8'h06;
    localparam logic [7:0]  IDX_DIG_OUT     = 8'h07;
    localparam logic [7:0]  IDX_ANA_OUT     = 8'h0C;
    localparam logic [15:0] CMD_RESET_VAL   = 16'h0000;

    // Run operation command field positions.
    localparam int unsigned RUN_FWD_BIT     = 0;
    localparam int unsigned RUN_REV_BIT     = 1;
    localparam int unsigned RUN_X_LSB       = 2;
    localparam int unsigned RUN_RST_BIT     = 15;
    localparam int unsigned NUM_X           = 9;

    // Multi-function input functions and their source split under link operation.
    localparam int unsigned NUM_FUNC        = 33;
    localparam logic [32:0] FUNC_LINK_ONLY  = 33'h038B9F800;
    localparam logic [32:0] FUNC_TERM_ONLY  = 33'h0C1460200;

    typedef enum logic [1:0] {
        ACT_STOP_NOW   = 2'b00,
        ACT_RUN_TIMED  = 2'b01,
        ACT_RUN_OR_TRIP = 2'b10,
        ACT_RUN_RESUME = 2'b11
    } slsm_action_type;

    typedef enum logic [1:0] {
        ST_NORMAL = 2'b00,
        ST_HOLD   = 2'b01,
        ST_TRIP   = 2'b10
    } slsm_state_type;

    typedef struct packed {
        logic soh;
        logic crc_ok;
        logic crc_bad_own;
        logic parity_err;
        logic other_err;
    } slsm_link_evt_type;

    typedef struct packed {
        slsm_action_type action_sel;
        logic [9:0]      action_timer;
        logic [5:0]      silence_sec;
    } slsm_cfg_type;

endpackage

//--- rtl/slsm_tick_div.sv
`timescale 1ns/1ps
module slsm_tick_div
    import slsm_pkg::*;
#(
    parameter int unsigned DIV = TICK_CYCLES
)
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    output logic      tick_q
);

    localparam int unsigned CW = $clog2(DIV);

    logic [CW-1:0] cnt_q;
    wire           wrap = (cnt_q == CW'(DIV - 1));

    // Free-running divider; one pulse per period so slow timers share one clock.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= wrap ? '0 : cnt_q + 1'b1;
            tick_q <= wrap;
        end
    end

endmodule

//--- rtl/slsm_clamp.sv
`timescale 1ns/1ps
module slsm_clamp
#(
    parameter int                 W    = 17,
    parameter logic signed [16:0] LO   = -17'sd20000,
    parameter logic signed [16:0] HI   = 17'sd20000
)
(
    input  wire logic signed [W-1:0] value_in,
    output logic signed [W-1:0]      value_out
);

    // Stored values may lie outside the range; only the acted-on copy is limited.
    assign value_out = (value_in < W'(LO)) ? W'(LO) :
                       (value_in > W'(HI)) ? W'(HI) : value_in;

endmodule

//--- sim/slsm_host_model.sv
`timescale 1ns/1ps
module slsm_host_model
    import slsm_pkg::*;
(
    input  wire logic        ref_clk,
    output slsm_link_evt_type link_evt
);
    initial link_evt = '0;

    // One-cycle event, then a quiet cycle.
    task automatic pulse(input logic [4:0] ev);
        @(negedge ref_clk);
        link_evt = ev;
        @(negedge ref_clk);
        link_evt = '0;
    endtask

    // Header, then verdict or fault.
    task automatic frame(input logic [4:0] ev);
        pulse(5'h10);
        pulse(ev);
    endtask
endmodule

//--- sim/slsm_supervisor_chk.sv
`timescale 1ns/1ps
module slsm_supervisor_chk
    import slsm_pkg::*;
(
    input wire logic                ref_clk,
    input wire logic                rst_n,
    input wire slsm_link_evt_type   link_evt,
    input wire logic                cmd_wr_en,
    input wire logic [7:0]          cmd_sel,
    input wire logic [15:0]         cmd_wdata,
    input wire logic signed [16:0]  freq_cmd_q,
    input wire logic                freq_is_per_unit_q,
    input wire logic [1:0]          run_direction_cmd_q,
    input wire logic [15:0]         digital_out_q,
    input wire logic signed [16:0]  analog_out_q,
    input wire logic                alarm_reset_q,
    input wire logic                link_fault_trip_q,
    input wire logic                link_hold_q,
    input wire logic [7:0]          last_err_code_q,
    input wire logic [3:0]          err_count_q
);
    logic armed_q, rst_bit_q, any_err, wr_run;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Port-level fault and run write decode.
    assign any_err = link_evt.crc_bad_own | link_evt.parity_err | link_evt.other_err;
    assign wr_run  = cmd_wr_en && (cmd_sel == IDX_RUN_OP);

    // Shadows of internal arming and reset bit.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            armed_q   <= 1'b0;
            rst_bit_q <= 1'b0;
        end
        else
        begin
            armed_q <= armed_q | link_evt.soh;
            if (wr_run)
                rst_bit_q <= cmd_wdata[15];
        end
    end

    sequence rst_fall_s;
        wr_run && !cmd_wdata[15] && rst_bit_q;
    endsequence
    sequence wr_dig_s;
        cmd_wr_en && cmd_sel == IDX_DIG_OUT && !link_hold_q && !link_fault_trip_q
        ##1 !cmd_wr_en && !link_hold_q && !link_fault_trip_q;
    endsequence

    err_sat_a: assert property (err_count_q <= ERR_TRIP_COUNT)
        else $error("count over trip");
    err_step_a: assert property (err_count_q > $past(err_count_q) |->
        $past(any_err) && err_count_q == $past(err_count_q) + 4'h1)
        else $error("count rose without fault");
    err_code_a: assert property (err_count_q > $past(err_count_q) |->
        last_err_code_q == ($past(link_evt.crc_bad_own) ? ERR_CODE_CRC :
        $past(link_evt.parity_err) ? ERR_CODE_PARITY : ERR_CODE_OTHER))
        else $error("wrong error code");
    crc_clear_a: assert property (link_evt.crc_ok && !any_err |=> err_count_q == 4'h0)
        else $error("good frame kept count");
    alarm_edge_a: assert property (rst_fall_s |-> ##2 alarm_reset_q ##1 !alarm_reset_q)
        else $error("no single alarm pulse");
    dig_follow_a: assert property (wr_dig_s |=> digital_out_q == $past(cmd_wdata, 2))
        else $error("digital out mismatch");
    out_clamp_a: assert property (analog_out_q >= PU_MIN && analog_out_q <= PU_MAX &&
        (freq_is_per_unit_q ? (freq_cmd_q >= PU_MIN && freq_cmd_q <= PU_MAX)
        : (freq_cmd_q >= HZ_MIN && freq_cmd_q <= HZ_MAX)))
        else $error("command out of range");
    hold_freeze_a: assert property (link_hold_q [*3] |-> $stable(freq_cmd_q)
        && $stable(run_direction_cmd_q))
        else $error("held command changed");
    trip_stop_a: assert property (link_fault_trip_q [*2] |-> run_direction_cmd_q == 2'b00)
        else $error("run in trip");
    unarmed_quiet_a: assert property (!armed_q |-> !link_fault_trip_q && !link_hold_q)
        else $error("action before header");
endmodule

bind slsm_supervisor slsm_supervisor_chk slsm_supervisor_chk_i (
    .ref_clk, .rst_n, .link_evt, .cmd_wr_en, .cmd_sel, .cmd_wdata, .freq_cmd_q,
    .freq_is_per_unit_q, .run_direction_cmd_q, .digital_out_q, .analog_out_q,
    .alarm_reset_q, .link_fault_trip_q, .link_hold_q, .last_err_code_q, .err_count_q
);

//--- sim/slsm_supervisor_tb.sv
`timescale 1ns/1ps
module slsm_supervisor_tb
    import slsm_pkg::*;
;
    localparam logic [4:0] EV_OK = 5'h08, EV_CRC = 5'h04, EV_PAR = 5'h02, EV_OTH = 5'h01;
    logic                  ref_clk, rst_n, link_freq_mode, link_run_mode;
    logic                  cmd_wr_en, cmd_rd_en, freq_is_per_unit_q, alarm_reset_q;
    logic                  link_fault_trip_q, link_hold_q;
    slsm_link_evt_type     link_evt;
    slsm_cfg_type          cfg;
    logic [7:0]            cmd_sel, last_err_code_q;
    logic [15:0]           cmd_wdata, cmd_rdata_q, digital_out_q;
    logic [1:0]            term_run_dir, run_direction_cmd_q;
    logic [NUM_X-1:0]      multi_function_inputs;
    logic [NUM_X-1:0][5:0] input_function_settings;
    logic signed [16:0]    freq_cmd_q, analog_out_q;
    logic [NUM_FUNC-1:0]   func_active_q;
    logic [3:0]            err_count_q;
    int                    fails, tests_run;
    logic [7:0]  sel_t [5] = '{IDX_FREQ_PU, IDX_FREQ_HZ, IDX_RUN_OP, IDX_DIG_OUT, IDX_ANA_OUT};
    logic [15:0] val_t [5] = '{16'h7FFF, 16'hAFC8, 16'h0002, 16'hA5C3, 16'h8AD0};

    always #20 ref_clk = ~ref_clk;

    slsm_host_model slsm_host_model_i (.ref_clk(ref_clk), .link_evt(link_evt));

    // Short tick keeps timers brief.
    slsm_supervisor #(.TICK_DIV(10)) slsm_supervisor_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .link_evt(link_evt), .cfg(cfg),
        .link_freq_mode(link_freq_mode), .link_run_mode(link_run_mode),
        .cmd_wr_en(cmd_wr_en), .cmd_rd_en(cmd_rd_en), .cmd_sel(cmd_sel),
        .cmd_wdata(cmd_wdata), .term_run_dir(term_run_dir),
        .multi_function_inputs(multi_function_inputs),
        .input_function_settings(input_function_settings), .cmd_rdata_q(cmd_rdata_q),
        .freq_cmd_q(freq_cmd_q), .freq_is_per_unit_q(freq_is_per_unit_q),
        .run_direction_cmd_q(run_direction_cmd_q), .func_active_q(func_active_q),
        .digital_out_q(digital_out_q), .analog_out_q(analog_out_q),
        .alarm_reset_q(alarm_reset_q), .link_fault_trip_q(link_fault_trip_q),
        .link_hold_q(link_hold_q), .last_err_code_q(last_err_code_q),
        .err_count_q(err_count_q)
    );

    task automatic tally_and_finish();
        $display("Checks %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // Strobes change on falling edges.
    task automatic wr(input logic [7:0] sel, input logic [15:0] data);
        @(negedge ref_clk);
        cmd_wr_en = 1'b1;
        cmd_sel = sel;
        cmd_wdata = data;
        @(negedge ref_clk);
        cmd_wr_en = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] sel, input logic [15:0] exp);
        @(negedge ref_clk);
        cmd_rd_en = 1'b1;
        cmd_sel = sel;
        @(negedge ref_clk);
        cmd_rd_en = 1'b0;
        chk(cmd_rdata_q, exp);
    endtask

    task automatic settle();
        repeat (4) @(negedge ref_clk);
    endtask

    task automatic frame(input logic [4:0] ev);
        slsm_host_model_i.frame(ev);
    endtask

    function automatic logic pick(input int w);
        case (w)
            0: return link_hold_q;
            1: return link_fault_trip_q;
            default: return alarm_reset_q;
        endcase
    endfunction

    // Bounded wait; timeout fails the run.
    task automatic wait_on(input int w, input int lim);
        int n;
        n = 0;
        while (pick(w) !== 1'b1 && n < lim)
        begin
            @(negedge ref_clk);
            n++;
        end
        tests_run++;
        if (pick(w) !== 1'b1)
        begin
            fails++;
            $display("MISMATCH %0t: wait %0d out", $time, w);
            tally_and_finish();
        end
    endtask

    // Run bits stay clear so a reset cannot restart the motor.
    task automatic do_alarm_reset();
        wr(IDX_RUN_OP, 16'h8000);
        wr(IDX_RUN_OP, 16'h0000);
        wait_on(2, 5);
    endtask

    initial
    begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        fails = 0;
        tests_run = 0;
        cfg = '0;
        link_freq_mode = 1'b1;
        link_run_mode = 1'b1;
        cmd_wr_en = 1'b0;
        cmd_rd_en = 1'b0;
        cmd_sel = 8'h00;
        cmd_wdata = 16'h0000;
        term_run_dir = 2'b01;
        multi_function_inputs = 9'h1FF;
        input_function_settings = {{6{6'h3F}}, 6'h07, 6'h09, 6'h0B};
        repeat (16) @(negedge ref_clk);
        rst_n = 1'b1;
        // Raw read-back, clamped outputs.
        for (int i = 0; i < 5; i++)
            wr(sel_t[i], val_t[i]);
        for (int i = 0; i < 5; i++)
            rd_chk(sel_t[i], val_t[i]);
        rd_chk(8'h02, 16'h0000);
        settle();
        chk(freq_cmd_q, PU_MAX);
        chk(freq_is_per_unit_q, 1'b1);
        chk(analog_out_q, PU_MIN);
        chk(digital_out_q, 16'hA5C3);
        chk(run_direction_cmd_q, 2'b10);
        chk({func_active_q[11], func_active_q[9], func_active_q[7]}, 3'b011);
        wr(IDX_FREQ_PU, 16'h0000);
        multi_function_inputs = 9'h000;
        wr(IDX_RUN_OP, 16'h07FE);
        settle();
        chk(freq_cmd_q, HZ_MAX);
        chk(freq_is_per_unit_q, 1'b0);
        chk({func_active_q[11], func_active_q[9], func_active_q[7]}, 3'b101);
        link_run_mode = 1'b0;
        settle();
        chk(run_direction_cmd_q, 2'b01);
        link_run_mode = 1'b1;
        do_alarm_reset();
        // Error counting and immediate stop.
        frame(EV_OK);
        repeat (3) frame(EV_CRC);
        chk(err_count_q, 4'h3);
        chk(last_err_code_q, ERR_CODE_CRC);
        frame(EV_OK);
        chk(err_count_q, 4'h0);
        slsm_host_model_i.pulse(5'h10);
        slsm_host_model_i.pulse(EV_PAR);
        slsm_host_model_i.pulse(EV_OTH);
        chk(err_count_q, 4'h1);
        chk(last_err_code_q, ERR_CODE_PARITY);
        repeat (6) frame(EV_OTH);
        chk(last_err_code_q, ERR_CODE_OTHER);
        chk(link_fault_trip_q, 1'b0);
        frame(EV_CRC);
        wait_on(1, 6);
        frame(EV_OK);
        do_alarm_reset();
        settle();
        chk(link_fault_trip_q, 1'b0);
        // Silence hold, auto resume.
        cfg.silence_sec = 6'h01;
        cfg.action_sel = ACT_RUN_RESUME;
        cfg.action_timer = 10'h002;
        wr(IDX_FREQ_PU, 16'h03E8);
        frame(EV_OK);
        repeat (70) @(negedge ref_clk);
        frame(EV_OK);
        repeat (70) @(negedge ref_clk);
        chk(link_hold_q, 1'b0);
        wait_on(0, 60);
        wr(IDX_FREQ_PU, 16'h1388);
        settle();
        chk(freq_cmd_q, 17'h003E8);
        rd_chk(IDX_FREQ_PU, 16'h1388);
        frame(EV_OK);
        settle();
        chk(link_hold_q, 1'b0);
        chk(freq_cmd_q, 17'h01388);
        // Timed modes trip on timer expiry.
        for (int s = 1; s < 3; s++)
        begin
            cfg.action_sel = slsm_action_type'(s);
            frame(EV_OK);
            wait_on(0, 130);
            chk(link_fault_trip_q, 1'b0);
            wait_on(1, 40);
            frame(EV_OK);
            do_alarm_reset();
        end
        tally_and_finish();
    end
endmodule
